// >>> rna_alloc.v
// Remote I/O number allocator: configuration walk and register port.
`timescale 1ns/100ps
module rna_alloc (
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    input  wire        mode_switch_six,
    input  wire        mode_switch_seven,
    output reg         src_req,
    output reg  [1:0]  src_sel,
    output reg  [5:0]  src_index,
    input  wire        src_ack,
    input  wire [15:0] src_word,
    output reg         ee_wr,
    output reg  [5:0]  ee_index,
    output reg  [15:0] ee_wdata,
    input  wire        ee_done,
    output reg         io_enable,
    output reg         cfg_done,
    output reg         cfg_invalid
);
`include "rna_regs.vh"

    localparam ST_SETTLE = 4'h0;
    localparam ST_P1_REQ = 4'h1;
    localparam ST_P1_WT  = 4'h2;
    localparam ST_P2_REQ = 4'h3;
    localparam ST_P2_WT  = 4'h4;
    localparam ST_EE_WT  = 4'h5;
    localparam ST_DONE   = 4'h6;
    localparam ST_FAIL   = 4'h7;
    localparam ST_BADSW  = 4'h8;

    function [9:0] round8;
        input [9:0] v;
        begin
            round8 = (v + `RNA_BLOCK_MASK) & ~`RNA_BLOCK_MASK;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////
    // State.

    reg [1:0]  sw6_sync_reg;
    reg [1:0]  sw7_sync_reg;
    reg [3:0]  state_reg;
    reg [2:0]  settle_reg;
    reg        cfg_mode_reg;
    reg        grp16_reg;
    reg [2:0]  ctl_reg;
    reg [9:0]  local_x_reg;
    reg [9:0]  local_y_reg;
    reg [5:0]  sel_reg;
    reg [5:0]  idx_reg;
    reg [9:0]  x_reg;
    reg [9:0]  y_reg;
    reg [7:0]  occ_reg;
    reg        ovf_reg;
    reg [9:0]  next_x_reg;
    reg [9:0]  next_y_reg;
    reg [7:0]  occ_total_reg;
    reg [15:0] scan_reg;
    reg [15:0] info_mem [0:63];
    reg [9:0]  xb_mem   [0:63];
    reg [9:0]  yb_mem   [0:63];
    reg [6:0]  stn_mem  [0:63];
    reg [1:0]  kind_mem [0:63];

    wire [9:0] step_x;
    wire [9:0] step_y;
    wire [7:0] step_occ;
    wire       step_present;
    wire       step_rdev;
    wire       sw6 = sw6_sync_reg[1];
    wire       sw7 = sw7_sync_reg[1];
    wire       last = (idx_reg == `RNA_LAST_INDEX);
    wire [7:0] info_off = addr - `RNA_ADDR_INFO_FIRST;

    rna_step u_step (
        .info    (src_word),
        .grp16   (grp16_reg),
        .x_in    (x_reg),
        .y_in    (y_reg),
        .occ_in  (occ_reg),
        .x_out   (step_x),
        .y_out   (step_y),
        .occ_out (step_occ),
        .present (step_present),
        .rdev    (step_rdev)
    );

    //////////////////////////////////////////////////////////////////////
    // Switch synchronisers.

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw6_sync_reg <= 2'h0;
            sw7_sync_reg <= 2'h0;
        end else if (ce) begin
            sw6_sync_reg <= {sw6_sync_reg[0], mode_switch_six};
            sw7_sync_reg <= {sw7_sync_reg[0], mode_switch_seven};
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Configuration walk.
    // Pass one only counts occupancy so that an overflowing set never
    // reaches the stored words; pass two fetches again and commits.
    // The sources must therefore answer both passes with the same data.

    integer i;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg     <= ST_SETTLE;
            settle_reg    <= 3'h0;
            cfg_mode_reg  <= 1'b0;
            grp16_reg     <= 1'b0;
            idx_reg       <= 6'h00;
            x_reg         <= 10'h000;
            y_reg         <= 10'h000;
            occ_reg       <= 8'h00;
            ovf_reg       <= 1'b0;
            next_x_reg    <= 10'h000;
            next_y_reg    <= 10'h000;
            occ_total_reg <= 8'h00;
            scan_reg      <= 16'h0000;
            src_req       <= 1'b0;
            src_sel       <= `RNA_SRC_NET;
            src_index     <= 6'h00;
            ee_wr         <= 1'b0;
            ee_index      <= 6'h00;
            ee_wdata      <= 16'h0000;
            io_enable     <= 1'b0;
            cfg_done      <= 1'b0;
            cfg_invalid   <= 1'b0;
            for (i = 0; i < 64; i = i + 1) begin
                info_mem[i] <= 16'h0000;
                xb_mem[i]   <= 10'h000;
                yb_mem[i]   <= 10'h000;
                stn_mem[i]  <= 7'h00;
                kind_mem[i] <= 2'h0;
            end
        end else if (ce) begin
            src_req <= 1'b0;
            ee_wr   <= 1'b0;
            case (state_reg)
                ST_SETTLE: begin
                    io_enable <= 1'b0;
                    cfg_done  <= 1'b0;
                    cfg_invalid <= 1'b0;
                    settle_reg <= settle_reg + 3'h1;
                    if (settle_reg == `RNA_SETTLE_CYCLES) begin
                        settle_reg   <= 3'h0;
                        cfg_mode_reg <= sw6 & ~sw7;
                        grp16_reg    <= ctl_reg[`RNA_CTL_GRP16];
                        idx_reg      <= 6'h00;
                        occ_reg      <= 8'h00;
                        ovf_reg      <= 1'b0;
                        if (sw6 ^ sw7) begin
                            state_reg <= ST_P1_REQ;
                        end else begin
                            state_reg <= ST_BADSW;
                        end
                        if (~sw6 & sw7) begin
                            src_sel <= `RNA_SRC_EEPROM;
                        end else if (ctl_reg[`RNA_CTL_PARAM]) begin
                            src_sel <= `RNA_SRC_PARAM;
                        end else begin
                            src_sel <= `RNA_SRC_NET;
                        end
                    end
                end
                ST_P1_REQ, ST_P2_REQ: begin
                    src_req   <= 1'b1;
                    src_index <= idx_reg;
                    state_reg <= state_reg + 4'h1;
                end
                ST_P1_WT: begin
                    if (src_ack) begin
                        occ_reg <= step_occ;
                        if (step_occ > `RNA_MAX_OCC) begin
                            ovf_reg <= 1'b1;
                        end
                        idx_reg <= idx_reg + 6'h01;
                        if (!last) begin
                            state_reg <= ST_P1_REQ;
                        end else if (ovf_reg || step_occ > `RNA_MAX_OCC) begin
                            state_reg   <= ST_FAIL;
                            cfg_invalid <= 1'b1;
                        end else begin
                            state_reg <= ST_P2_REQ;
                            occ_reg   <= 8'h00;
                            x_reg     <= round8(local_x_reg);
                            y_reg     <= round8(local_y_reg);
                        end
                    end
                end
                ST_P2_WT: begin
                    if (src_ack) begin
                        info_mem[idx_reg] <= src_word;
                        xb_mem[idx_reg]   <= x_reg;
                        yb_mem[idx_reg]   <= y_reg;
                        stn_mem[idx_reg]  <= occ_reg[6:0] + 7'h01;
                        kind_mem[idx_reg] <= {step_rdev, step_present};
                        x_reg   <= step_x;
                        y_reg   <= step_y;
                        occ_reg <= step_occ;
                        if (cfg_mode_reg) begin
                            ee_wr     <= 1'b1;
                            ee_index  <= idx_reg;
                            ee_wdata  <= src_word;
                            state_reg <= ST_EE_WT;
                        end else if (last) begin
                            state_reg <= ST_DONE;
                        end else begin
                            idx_reg   <= idx_reg + 6'h01;
                            state_reg <= ST_P2_REQ;
                        end
                    end
                end
                ST_EE_WT: begin
                    if (ee_done) begin
                        idx_reg <= idx_reg + 6'h01;
                        if (last) begin
                            state_reg <= ST_DONE;
                        end else begin
                            state_reg <= ST_P2_REQ;
                        end
                    end
                end
                ST_DONE: begin
                    if (!cfg_done) begin
                        next_x_reg    <= round8(x_reg);
                        next_y_reg    <= round8(y_reg);
                        occ_total_reg <= occ_reg;
                        // Each 16-point station carries a wider frame.
                        if (grp16_reg) begin
                            scan_reg <= occ_reg * `RNA_SCAN_UNIT_16;
                        end else begin
                            scan_reg <= occ_reg * `RNA_SCAN_UNIT_4;
                        end
                    end
                    cfg_done    <= 1'b1;
                    cfg_invalid <= 1'b0;
                    io_enable   <= ~cfg_mode_reg;
                end
                ST_FAIL, ST_BADSW: begin
                    io_enable <= 1'b0;
                end
                default: begin
                    state_reg <= ST_SETTLE;
                end
            endcase
            // Restart stands for a power cycle; the walk begins again.
            if (wr && addr == `RNA_ADDR_CONTROL &&
                wdata[`RNA_CTL_RESTART]) begin
                state_reg  <= ST_SETTLE;
                settle_reg <= 3'h0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Register port.

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_reg     <= `RNA_CTL_RESET;
            local_x_reg <= 10'h000;
            local_y_reg <= 10'h000;
            sel_reg     <= 6'h00;
        end else if (ce && wr) begin
            case (addr)
                `RNA_ADDR_CONTROL: ctl_reg     <= {1'b0, wdata[1:0]};
                `RNA_ADDR_LOCAL_X: local_x_reg <= wdata[9:0];
                `RNA_ADDR_LOCAL_Y: local_y_reg <= wdata[9:0];
                `RNA_ADDR_SEL:     sel_reg     <= wdata[5:0];
                default:           sel_reg     <= sel_reg;
            endcase
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 16'h0000;
        end else if (ce) begin
            rdata <= 16'h0000;
            if (rd) begin
                if (addr >= `RNA_ADDR_INFO_FIRST &&
                    addr <= `RNA_ADDR_INFO_LAST) begin
                    rdata <= info_mem[info_off[5:0]];
                end else begin
                    case (addr)
                        `RNA_ADDR_STATUS:
                            rdata <= {8'h00, state_reg, cfg_mode_reg,
                                      grp16_reg, cfg_invalid, cfg_done};
                        `RNA_ADDR_CONTROL:  rdata <= {13'h0000, ctl_reg};
                        `RNA_ADDR_LOCAL_X:  rdata <= {6'h00, local_x_reg};
                        `RNA_ADDR_LOCAL_Y:  rdata <= {6'h00, local_y_reg};
                        `RNA_ADDR_SEL:      rdata <= {10'h000, sel_reg};
                        `RNA_ADDR_RES_X:    rdata <= {6'h00, xb_mem[sel_reg]};
                        `RNA_ADDR_RES_Y:    rdata <= {6'h00, yb_mem[sel_reg]};
                        `RNA_ADDR_RES_STN:
                            rdata <= {7'h00, kind_mem[sel_reg],
                                      stn_mem[sel_reg]};
                        `RNA_ADDR_RES_WORD: begin
                            if (kind_mem[sel_reg][1]) begin
                                rdata <= {8'h00, `RNA_RD_WORD_BASE +
                                          {1'b0, stn_mem[sel_reg]}};
                            end
                        end
                        `RNA_ADDR_OCCUPIED: rdata <= {8'h00, occ_total_reg};
                        `RNA_ADDR_NEXT_X:   rdata <= {6'h00, next_x_reg};
                        `RNA_ADDR_NEXT_Y:   rdata <= {6'h00, next_y_reg};
                        `RNA_ADDR_SCAN:     rdata <= scan_reg;
                        default:            rdata <= 16'h0000;
                    endcase
                end
            end
        end
    end

endmodule // rna_alloc

// >>> rna_regs.vh
// Constants shared by the remote I/O number allocator.
`ifndef RNA_REGS_VH
`define RNA_REGS_VH

// Register port word addresses.
`define RNA_ADDR_STATUS     8'h00
`define RNA_ADDR_CONTROL    8'h01
`define RNA_ADDR_LOCAL_X    8'h02
`define RNA_ADDR_LOCAL_Y    8'h03
`define RNA_ADDR_SEL        8'h04
`define RNA_ADDR_RES_X      8'h05
`define RNA_ADDR_RES_Y      8'h06
`define RNA_ADDR_RES_STN    8'h07
`define RNA_ADDR_RES_WORD   8'h08
`define RNA_ADDR_OCCUPIED   8'h09
`define RNA_ADDR_NEXT_X     8'h0A
`define RNA_ADDR_NEXT_Y     8'h0B
`define RNA_ADDR_SCAN       8'h0C
`define RNA_ADDR_INFO_FIRST 8'h20
`define RNA_ADDR_INFO_LAST  8'h5F

// Control register fields and reset value.
`define RNA_CTL_GRP16       0
`define RNA_CTL_PARAM       1
`define RNA_CTL_RESTART     2
`define RNA_CTL_RESET       3'h0

// Station information word layout.
`define RNA_INFO_IN_LSB     0
`define RNA_INFO_IN_MSB     4
`define RNA_INFO_OUT_LSB    5
`define RNA_INFO_OUT_MSB    9
`define RNA_INFO_RDEV       10
`define RNA_INFO_RSIZE_LSB  11
`define RNA_INFO_RSIZE_MSB  12

// Source selection codes for the station word fetch port.
`define RNA_SRC_NET         2'h0
`define RNA_SRC_PARAM       2'h1
`define RNA_SRC_EEPROM      2'h2

// Counts and limits.
`define RNA_STATIONS        7'h40
`define RNA_LAST_INDEX      6'h3F
`define RNA_MAX_OCC         8'h40
`define RNA_RD_WORD_BASE    8'h9F
`define RNA_BLOCK_MASK      10'h007
`define RNA_SETTLE_CYCLES   3'h4
`define RNA_SCAN_UNIT_4     16'h0001
`define RNA_SCAN_UNIT_16    16'h0004

`endif

// >>> rna_step.v
// One station step of the allocator: occupancy and I/O number advance.
`timescale 1ns/100ps
module rna_step (
    input  wire [15:0] info,
    input  wire        grp16,
    input  wire [9:0]  x_in,
    input  wire [9:0]  y_in,
    input  wire [7:0]  occ_in,
    output reg  [9:0]  x_out,
    output reg  [9:0]  y_out,
    output reg  [7:0]  occ_out,
    output reg         present,
    output reg         rdev
);
`include "rna_regs.vh"

    reg [4:0] in_pts;
    reg [4:0] out_pts;
    reg [6:0] total;
    reg [6:0] stations;

    always @* begin
        in_pts  = info[`RNA_INFO_IN_MSB:`RNA_INFO_IN_LSB];
        out_pts = info[`RNA_INFO_OUT_MSB:`RNA_INFO_OUT_LSB];
        rdev    = info[`RNA_INFO_RDEV];
        // A device station declares 16, 32, 48 or 64 points.
        if (rdev) begin
            total = {info[`RNA_INFO_RSIZE_MSB:`RNA_INFO_RSIZE_LSB], 4'h0}
                    + 7'h10;
        end else begin
            total = {2'h0, in_pts} + {2'h0, out_pts};
        end
        present = (total != 7'h00);
        if (grp16) begin
            stations = (total + 7'h0F) >> 4;
        end else begin
            stations = (total + 7'h03) >> 2;
        end
        occ_out = occ_in + {1'b0, stations};
        // Numbers never look at the grouping; a device station takes none, others advance by their points.
        if (rdev) begin
            x_out = x_in;
            y_out = y_in;
        end else begin
            x_out = x_in + {5'h00, in_pts};
            y_out = y_in + {5'h00, out_pts};
        end
    end

endmodule // rna_step

// >>> rna_alloc_chk.sv
// Concurrent checks on the ports of the remote I/O number allocator.
`timescale 1ns/100ps
`include "rna_regs.vh"
module rna_alloc_chk (
    input wire        clk,
    input wire        resetn,
    input wire        rd,
    input wire [15:0] rdata,
    input wire        mode_switch_six,
    input wire        mode_switch_seven,
    input wire        src_req,
    input wire [1:0]  src_sel,
    input wire [5:0]  src_index,
    input wire        src_ack,
    input wire        ee_wr,
    input wire        io_enable,
    input wire        cfg_done,
    input wire        cfg_invalid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    sequence s_req_pulse;
        src_req ##1 !src_req;
    endsequence
    sequence s_ee_pulse;
        ee_wr ##1 !ee_wr;
    endsequence
    // The pins pass a two-stage synchroniser, so look three edges back.
    sequence s_cfg_pins;
        mode_switch_six && !mode_switch_seven &&
        $past(mode_switch_six, 3) && !$past(mode_switch_seven, 3);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (
        !$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_req_pulse: assert property (src_req |-> s_req_pulse)
        else $error("fetch request longer than one cycle");
    a_ee_pulse: assert property (ee_wr |-> s_ee_pulse)
        else $error("EEPROM write longer than one cycle");
    a_ee_after_ack: assert property (ee_wr |-> $past(src_ack))
        else $error("EEPROM write not right after a fetch answer");
    a_ee_not_online: assert property (
        ee_wr |-> src_sel != `RNA_SRC_EEPROM && !io_enable)
        else $error("EEPROM written while reading it back");
    a_cfg_io_off: assert property (s_cfg_pins |-> !io_enable)
        else $error("I/O active in configuration mode");
    a_invalid_io: assert property (cfg_invalid |-> !io_enable)
        else $error("I/O active on an invalid configuration");
    a_io_done: assert property (io_enable |-> cfg_done)
        else $error("I/O active before configuration committed");
    // The source moves only while the walk settles, never under an answer.
    a_fetch_hold: assert property (!src_req |->
        $stable(src_index) && (!src_ack || $stable(src_sel)))
        else $error("fetch slot or source moved between requests");
endmodule // rna_alloc_chk

bind rna_alloc rna_alloc_chk chk_u (
    .clk(clk), .resetn(resetn), .rd(rd), .rdata(rdata),
    .mode_switch_six(mode_switch_six), .mode_switch_seven(mode_switch_seven),
    .src_req(src_req), .src_sel(src_sel), .src_index(src_index),
    .src_ack(src_ack), .ee_wr(ee_wr), .io_enable(io_enable),
    .cfg_done(cfg_done), .cfg_invalid(cfg_invalid)
);

// >>> rna_stations.sv
// Behavioural model of the remote stations, parameter store and EEPROM.
`timescale 1ns/100ps
module rna_stations (
    input wire        clk,
    input wire        resetn,
    input wire        slow,
    input wire        src_req,
    input wire [1:0]  src_sel,
    input wire [5:0]  src_index,
    output reg        src_ack,
    output reg [15:0] src_word,
    input wire        ee_wr,
    input wire [5:0]  ee_index,
    input wire [15:0] ee_wdata,
    output reg        ee_done
);
    reg  [15:0] net_mem [0:63];
    reg  [15:0] par_mem [0:63];
    reg  [15:0] ee_mem  [0:63];
    reg  [1:0]  wait_cnt;
    reg         busy;
    reg  [1:0]  ee_cnt;
    integer     k;
    wire [15:0] word_sel = src_sel == 2'h0 ? net_mem[src_index] :
                           src_sel == 2'h1 ? par_mem[src_index] :
                           ee_mem[src_index];

    // The EEPROM keeps its contents across resets, so it is cleared once.
    initial begin
        for (k = 0; k < 64; k = k + 1)
            ee_mem[k] = 16'h0000;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy     <= 1'b0;
            wait_cnt <= 2'd0;
            src_ack  <= 1'b0;
            src_word <= 16'h0000;
            ee_cnt   <= 2'd0;
            ee_done  <= 1'b0;
        end else begin
            src_ack  <= 1'b0;
            // Outside an answer the word toggles so stale data never passes.
            src_word <= ~src_word;
            ee_done  <= 1'b0;
            if (src_req) begin
                busy     <= 1'b1;
                wait_cnt <= slow ? 2'd3 : 2'd0;
            end else if (busy && wait_cnt != 2'd0) begin
                wait_cnt <= wait_cnt - 2'd1;
            end else if (busy) begin
                busy     <= 1'b0;
                src_ack  <= 1'b1;
                src_word <= word_sel;
            end
            if (ee_wr) begin
                ee_mem[ee_index] <= ee_wdata;
                ee_cnt           <= 2'd2;
            end else if (ee_cnt != 2'd0) begin
                ee_cnt  <= ee_cnt - 2'd1;
                ee_done <= ee_cnt == 2'd1;
            end
        end
    end
endmodule // rna_stations

// >>> rna_alloc_test.sv
// Self-checking bench for the remote I/O number allocator.
`timescale 1ns/100ps
`include "rna_regs.vh"
module rna_alloc_test;
    reg         clk;
    reg         resetn;
    reg         ce;
    reg  [7:0]  addr;
    reg  [15:0] wdata;
    reg         wr;
    reg         rd;
    reg         mode_switch_six;
    reg         mode_switch_seven;
    reg         slow;
    wire [15:0] rdata;
    wire [15:0] src_word;
    wire [15:0] ee_wdata;
    wire [1:0]  src_sel;
    wire [5:0]  src_index;
    wire [5:0]  ee_index;
    wire        src_req;
    wire        src_ack;
    wire        ee_wr;
    wire        ee_done;
    wire        io_enable;
    wire        cfg_done;
    wire        cfg_invalid;
    integer     fails;
    integer     total_checks;
    integer     i;

    rna_alloc dut_u (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .mode_switch_six(mode_switch_six), .mode_switch_seven(mode_switch_seven),
        .src_req(src_req), .src_sel(src_sel), .src_index(src_index),
        .src_ack(src_ack), .src_word(src_word), .ee_wr(ee_wr),
        .ee_index(ee_index), .ee_wdata(ee_wdata), .ee_done(ee_done),
        .io_enable(io_enable), .cfg_done(cfg_done), .cfg_invalid(cfg_invalid));
    rna_stations pm_u (.clk(clk), .resetn(resetn), .slow(slow),
        .src_req(src_req), .src_sel(src_sel), .src_index(src_index),
        .src_ack(src_ack), .src_word(src_word), .ee_wr(ee_wr),
        .ee_index(ee_index), .ee_wdata(ee_wdata), .ee_done(ee_done));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task check(input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t: saw %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask

    task reg_wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr  <= a;
            wdata <= d;
            wr    <= 1'b1;
            @(posedge clk);
            wr    <= 1'b0;
        end
    endtask

    task rd_chk(input [7:0] a, input [15:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd   <= 1'b1;
            @(posedge clk);
            rd   <= 1'b0;
            #1;
            check(rdata, e);
        end
    endtask

    // An X or Y value of all ones skips that field.
    task slot_chk(input [5:0] s, input [15:0] ex, input [15:0] ey,
                  input [15:0] es);
        begin
            reg_wr(`RNA_ADDR_SEL, {10'h000, s});
            if (ex != 16'hFFFF)
                rd_chk(`RNA_ADDR_RES_X, ex);
            if (ey != 16'hFFFF)
                rd_chk(`RNA_ADDR_RES_Y, ey);
            rd_chk(`RNA_ADDR_RES_STN, es);
        end
    endtask

    // The fetch stays silent if the walk never starts, so both waits are cut.
    task walk;
        integer n;
        begin
            n = 0;
            while (!src_req && n < 200) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            while (!(cfg_done || cfg_invalid) && n < 20000) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (n >= 20000)
                check(16'h0001, 16'h0000);
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    initial begin
        #5_000_000;
        fails = fails + 1;
        complete_run;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        slow = 1'b0;
        mode_switch_six = 1'b1;
        mode_switch_seven = 1'b0;
        fails = 0;
        total_checks = 0;
        for (i = 0; i < 64; i = i + 1) begin
            pm_u.net_mem[i] = 16'h0000;
            pm_u.par_mem[i] = 16'h0000;
        end
        pm_u.net_mem[0] = 16'h0004;
        pm_u.net_mem[1] = 16'h0042;
        pm_u.net_mem[2] = 16'h0010;
        pm_u.net_mem[3] = 16'h0042;
        pm_u.net_mem[4] = 16'h0004;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        walk;
        rd_chk(`RNA_ADDR_CONTROL, 16'h0000);
        rd_chk(8'h10, 16'h0000);
        reg_wr(`RNA_ADDR_LOCAL_X, 16'h001E);
        reg_wr(`RNA_ADDR_LOCAL_Y, 16'h000D);
        reg_wr(`RNA_ADDR_CONTROL, 16'h0004);
        walk;
        slot_chk(0, 16'h0020, 16'hFFFF, 16'h0081);
        slot_chk(1, 16'h0024, 16'h0010, 16'h0082);
        slot_chk(2, 16'h0026, 16'hFFFF, 16'h0083);
        slot_chk(3, 16'h0036, 16'h0012, 16'h0087);
        slot_chk(4, 16'h0038, 16'hFFFF, 16'h0088);
        rd_chk(`RNA_ADDR_NEXT_X, 16'h0040);
        rd_chk(`RNA_ADDR_NEXT_Y, 16'h0018);
        rd_chk(`RNA_ADDR_OCCUPIED, 16'h0008);
        rd_chk(`RNA_ADDR_SCAN, 16'h0008);
        for (i = 0; i < 6; i = i + 1) begin
            rd_chk(`RNA_ADDR_INFO_FIRST + i[7:0], pm_u.net_mem[i]);
            check(pm_u.ee_mem[i], pm_u.net_mem[i]);
        end
        check({15'h0000, io_enable}, 16'h0000);
        reg_wr(`RNA_ADDR_INFO_FIRST, 16'h1234);
        rd_chk(`RNA_ADDR_INFO_FIRST, 16'h0004);
        $display("test 1 done");
        pm_u.net_mem[5] = 16'h0400;
        reg_wr(`RNA_ADDR_CONTROL, 16'h0005);
        walk;
        slot_chk(2, 16'h0026, 16'hFFFF, 16'h0083);
        slot_chk(3, 16'h0036, 16'h0012, 16'h0084);
        slot_chk(5, 16'hFFFF, 16'hFFFF, 16'h0186);
        rd_chk(`RNA_ADDR_RES_WORD, 16'h00A5);
        rd_chk(`RNA_ADDR_NEXT_X, 16'h0040);
        rd_chk(`RNA_ADDR_OCCUPIED, 16'h0006);
        rd_chk(`RNA_ADDR_SCAN, 16'h0018);
        rd_chk(`RNA_ADDR_CONTROL, 16'h0001);
        rd_chk(`RNA_ADDR_STATUS, 16'h006D);
        $display("test 2 done");
        for (i = 0; i < 64; i = i + 1)
            pm_u.par_mem[i] = pm_u.net_mem[i];
        pm_u.par_mem[0] = 16'h0008;
        reg_wr(`RNA_ADDR_CONTROL, 16'h0007);
        walk;
        slot_chk(1, 16'h0028, 16'h0010, 16'h0082);
        rd_chk(`RNA_ADDR_INFO_FIRST, 16'h0008);
        check(pm_u.ee_mem[0], 16'h0008);
        $display("test 3 done");
        slow <= 1'b1;
        for (i = 0; i < 63; i = i + 1)
            pm_u.net_mem[i] = 16'h0021;
        pm_u.net_mem[63] = 16'h0008;
        reg_wr(`RNA_ADDR_CONTROL, 16'h0004);
        walk;
        check({15'h0000, cfg_invalid}, 16'h0001);
        rd_chk(`RNA_ADDR_INFO_FIRST, 16'h0008);
        check(pm_u.ee_mem[0], 16'h0008);
        rd_chk(`RNA_ADDR_NEXT_X, 16'h0040);
        reg_wr(`RNA_ADDR_CONTROL, 16'h0005);
        walk;
        check({14'h0000, cfg_done, cfg_invalid}, 16'h0002);
        rd_chk(`RNA_ADDR_OCCUPIED, 16'h0040);
        check(pm_u.ee_mem[63], 16'h0008);
        $display("test 4 done");
        @(posedge clk);
        slow <= 1'b0;
        resetn <= 1'b0;
        mode_switch_six <= 1'b0;
        mode_switch_seven <= 1'b1;
        pm_u.net_mem[0] = 16'h0000;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        walk;
        check({15'h0000, cfg_invalid}, 16'h0001);
        reg_wr(`RNA_ADDR_LOCAL_X, 16'h0021);
        reg_wr(`RNA_ADDR_LOCAL_Y, 16'h0009);
        reg_wr(`RNA_ADDR_CONTROL, 16'h0005);
        walk;
        check({15'h0000, io_enable}, 16'h0001);
        rd_chk(`RNA_ADDR_INFO_FIRST, 16'h0021);
        rd_chk(`RNA_ADDR_INFO_LAST, 16'h0008);
        slot_chk(1, 16'h0029, 16'h0011, 16'h0082);
        $display("test 5 done");
        complete_run;
    end
endmodule // rna_alloc_test
